// ---- csst_pkg.sv ----
// Package: offsets, reset values and sizes of the message slot status block
package csst_pkg;
   localparam int NUM_SLOTS = 15;
   localparam logic [7:0] ADDR_IRQ_HI = 8'hBA;
   localparam logic [7:0] ADDR_IRQ_LO = 8'hBB;
   localparam logic [7:0] ADDR_BUSY_HI = 8'hCE;
   localparam logic [7:0] ADDR_BUSY_LO = 8'hCF;
   localparam logic [14:0] BUSY_RESET = 15'h0000;
   localparam logic [14:0] IRQ_RESET = 15'h0000;
   localparam logic RSVD_READ = 1'b0;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam int LO_MSB = 7;
   localparam int HI_LSB = 8;
endpackage

// ---- csst_slot_status.sv ----
// Message slot busy and interrupt-pending status registers
//
// Contract
// [RULE1] Register at CEh bits 6-0 show busy state of slots 14 to 8.
// [RULE2] Register at CFh bits 7-0 show busy state of slots 7 to 0.
// [RULE3] Busy sets on enable, clears on done, disable, abort or standby; the code lets transmit done not clear auto reply slots.
// [RULE4] Register at BAh bits 6-0 show pending interrupts of slots 14 to 8.
// [RULE5] Register at BBh bits 7-0 show pending interrupts of slots 7 to 0.
// [RULE6] Bit 7 of both upper registers is reserved; software writes 0.
// [RULE7] Upper busy and interrupt registers read zero after reset.
// [RULE8] Writes to these four registers are ignored.
`timescale 1ns/100ps
`default_nettype none
module csst_slot_status #(
   parameter int N = csst_pkg::NUM_SLOTS
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [14:0] SLOT_ENABLE,
   input wire logic [14:0] SLOT_DISABLE,
   input wire logic [14:0] TX_DONE_FLAG,
   input wire logic [14:0] RX_DONE_FLAG,
   input wire logic [14:0] AUTO_REPLY_MODE,
   input wire logic ABORT_REQ,
   input wire logic STANDBY_REQ,
   input wire logic [14:0] SLOT_IRQ_COND,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_RD,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   output logic [14:0] SLOT_BUSY
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Flags that were low last edge and are high now
   function automatic logic [N-1:0] rise_of(
      input logic [N-1:0] now_v,
      input logic [N-1:0] was_v
   );
      rise_of = now_v & ~was_v;
   endfunction

   // Upper register: reserved top bit, then slots 14 to 8
   function automatic logic [7:0] pack_upper(
      input logic [N-1:0] v
   );
      pack_upper = {csst_pkg::RSVD_READ, v[N-1:csst_pkg::HI_LSB]};
   endfunction

   // Lower register: slots 7 to 0
   function automatic logic [7:0] pack_lower(
      input logic [N-1:0] v
   );
      pack_lower = v[csst_pkg::LO_MSB:0];
   endfunction

   // One of the four status addresses
   function automatic logic is_mapped(
      input logic [7:0] a
   );
      is_mapped = (a == csst_pkg::ADDR_BUSY_HI)
               || (a == csst_pkg::ADDR_BUSY_LO)
               || (a == csst_pkg::ADDR_IRQ_HI)
               || (a == csst_pkg::ADDR_IRQ_LO);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [N-1:0] busy_q;
   logic [N-1:0] busy_d;
   logic [N-1:0] irq_q;
   logic [N-1:0] tx_prev_q;
   logic [N-1:0] rx_prev_q;
   logic [N-1:0] tx_rise;
   logic [N-1:0] rx_rise;
   logic [N-1:0] set_mask;
   logic [N-1:0] clr_mask;
   logic clr_all;
   logic rd_hit;
   logic [7:0] rd_word;
   logic [7:0] rdata_d;

   ////////////////////////////////////////////////////////////////////////
   // Done flag edge detection

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_prev_q <= '0;
      end else begin
         tx_prev_q <= TX_DONE_FLAG;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_prev_q <= '0;
      end else begin
         rx_prev_q <= RX_DONE_FLAG;
      end
   end

   // Auto reply slots stay busy after their transmission
   always_comb begin
      tx_rise = rise_of(TX_DONE_FLAG, tx_prev_q) & ~AUTO_REPLY_MODE; // RULE3
   end

   always_comb begin
      rx_rise = rise_of(RX_DONE_FLAG, rx_prev_q); // RULE3
   end

   ////////////////////////////////////////////////////////////////////////
   // Busy tracking

   always_comb begin
      set_mask = SLOT_ENABLE; // RULE3
   end

   always_comb begin
      clr_mask = tx_rise | rx_rise | SLOT_DISABLE; // RULE3
   end

   always_comb begin
      clr_all = ABORT_REQ || STANDBY_REQ; // RULE3
   end

   // Clear beats enable; abort and standby beat everything
   always_comb begin
      busy_d = busy_q | set_mask; // RULE3
      busy_d = busy_d & ~clr_mask; // RULE3
      if (clr_all) begin
         busy_d = '0; // RULE3
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         busy_q <= csst_pkg::BUSY_RESET; // RULE7
      end else begin
         busy_q <= busy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pending follows each slot's condition

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_q <= csst_pkg::IRQ_RESET; // RULE7
      end else begin
         irq_q <= SLOT_IRQ_COND; // RULE4 RULE5
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port; writes have no path into the state

   always_comb begin
      rd_hit = SFR_RD && is_mapped(SFR_ADDR);
   end

   always_comb begin
      rd_word = csst_pkg::RDATA_RESET;
      unique case (SFR_ADDR)
         csst_pkg::ADDR_BUSY_HI: begin
            rd_word = pack_upper(busy_q); // RULE1 RULE6
         end
         csst_pkg::ADDR_BUSY_LO: begin
            rd_word = pack_lower(busy_q); // RULE2
         end
         csst_pkg::ADDR_IRQ_HI: begin
            rd_word = pack_upper(irq_q); // RULE4 RULE6
         end
         csst_pkg::ADDR_IRQ_LO: begin
            rd_word = pack_lower(irq_q); // RULE5
         end
         default: begin
            rd_word = csst_pkg::RDATA_RESET;
         end
      endcase
   end

   // Unmapped reads and all writes keep the last read data
   always_comb begin
      if (rd_hit) begin
         rdata_d = rd_word;
      end else begin
         rdata_d = SFR_RDATA; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output registers

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         SFR_RDATA <= csst_pkg::RDATA_RESET;
      end else begin
         SFR_RDATA <= rdata_d; // RULE8
      end
   end

   // Same value as the busy state, straight from a flip-flop
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         SLOT_BUSY <= csst_pkg::BUSY_RESET;
      end else begin
         SLOT_BUSY <= busy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hazards for users
   //
   // Done flags act on their rising edge only; a flag held high
   // does not clear a slot enabled later.
   // The reserved top bits always read 0.
   // SFR_WR and SFR_WDATA are accepted and never used.

endmodule
`default_nettype wire

// ---- csst_properties.sv ----
// Checker of slot status register read timing
`timescale 1ns/100ps
`default_nettype none
module csst_properties (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic ABORT_REQ,
   input wire logic STANDBY_REQ,
   input wire logic [14:0] SLOT_IRQ_COND,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_RDATA,
   input wire logic [14:0] SLOT_BUSY
);
default clocking @(posedge CLK); endclocking
default disable iff (!RSTN);
a_busy_hi_read: assert property (SFR_RD && SFR_ADDR == 8'hCE |=>
   SFR_RDATA == {1'b0, $past(SLOT_BUSY[14:8])}) else $error("busy hi");
a_busy_lo_read: assert property (SFR_RD && SFR_ADDR == 8'hCF |=>
   SFR_RDATA == $past(SLOT_BUSY[7:0])) else $error("busy lo");
a_irq_lo_read: assert property (SFR_RD && SFR_ADDR == 8'hBB |=>
   SFR_RDATA == $past(SLOT_IRQ_COND[7:0], 2)) else $error("irq lo");
a_irq_hi_read: assert property (SFR_RD && SFR_ADDR == 8'hBA |=>
   SFR_RDATA == {1'b0, $past(SLOT_IRQ_COND[14:8], 2)}) else $error("irq hi");
a_abort_clears_busy: assert property (ABORT_REQ |=> SLOT_BUSY == 15'h0)
   else $error("abort");
a_standby_clears_busy: assert property (STANDBY_REQ |=>
   SLOT_BUSY == 15'h0) else $error("standby");
a_rdata_holds: assert property (!SFR_RD |=> $stable(SFR_RDATA))
   else $error("rdata moved");
cover property (ABORT_REQ);
cover property (SFR_RD && SFR_ADDR == 8'hBA);
cover property (SLOT_BUSY != 15'h0);
endmodule
bind csst_slot_status csst_properties i_chk (.*);
`default_nettype wire

// ---- csst_cpu.sv ----
// Processor core model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module csst_cpu (
   input wire logic CLK,
   output logic [7:0] SFR_ADDR,
   output logic SFR_RD,
   output logic SFR_WR,
   output logic [7:0] SFR_WDATA
);
initial {SFR_ADDR, SFR_RD, SFR_WR, SFR_WDATA} = 18'h0;
task automatic acc(input logic [7:0] a, input logic w);
   @(posedge CLK);
   SFR_ADDR <= a;
   {SFR_RD, SFR_WR} <= {!w, w};
   SFR_WDATA <= 8'h7F;
   @(posedge CLK);
   {SFR_RD, SFR_WR} <= 2'h0;
endtask
endmodule
`default_nettype wire

// ---- tb_can_msg_slot_status_regs.sv ----
// Testbench of the slot status registers
`timescale 1ns/100ps
`default_nettype none
module tb_can_msg_slot_status_regs;
logic clk, rstn, ab, sb;
logic [14:0] en, dis, tx, rx, ar, irq;
wire logic [7:0] addr, wd, rd;
wire logic rds, wrs;
wire logic [14:0] busy;
int miscompares, tests_run, cyc;
csst_slot_status i_dut (.CLK(clk), .RSTN(rstn), .SLOT_ENABLE(en),
   .SLOT_DISABLE(dis), .TX_DONE_FLAG(tx), .RX_DONE_FLAG(rx),
   .AUTO_REPLY_MODE(ar), .ABORT_REQ(ab), .STANDBY_REQ(sb),
   .SLOT_IRQ_COND(irq), .SFR_ADDR(addr), .SFR_RD(rds), .SFR_WR(wrs),
   .SFR_WDATA(wd), .SFR_RDATA(rd), .SLOT_BUSY(busy));
csst_cpu i_cpu (.CLK(clk), .SFR_ADDR(addr), .SFR_RD(rds), .SFR_WR(wrs),
   .SFR_WDATA(wd));
task automatic test_done;
   if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
   tests_run++;
   if (seen !== exp) begin
      miscompares++;
      $display("wrong value %0t %h %h", $time, seen, exp);
   end
endtask
task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
   i_cpu.acc(a, 1'b0);
   #1;
   chk(rd, e);
endtask
initial begin
   clk = 0;
   forever #20 clk = ~clk;
end
always @(posedge clk) if (++cyc == 600) begin
   miscompares++;
   test_done();
end
initial begin
   {rstn, ab, sb, en, dis, tx, rx, ar, irq} = '0;
   repeat (2) @(posedge clk);
   rstn <= 1;
   rdchk(8'hCE, 8'h00);
   rdchk(8'hBA, 8'h00);
   @(posedge clk) en <= 15'h4081;
   @(posedge clk) en <= 15'h0;
   rdchk(8'hCE, 8'h40);
   chk(busy, 15'h4081);
   i_cpu.acc(8'hCF, 1'b1);
   rdchk(8'hCF, 8'h81);
   @(posedge clk) {tx, rx, ar} <= {15'h0081, 15'h4000, 15'h0080};
   rdchk(8'hCF, 8'h80);
   rdchk(8'hCE, 8'h00);
   @(posedge clk) ab <= 1;
   @(posedge clk) {ab, irq} <= {1'b0, 15'h4009};
   rdchk(8'hCF, 8'h00);
   rdchk(8'hBA, 8'h40);
   rdchk(8'hBB, 8'h09);
   rdchk(8'h55, 8'h09);
   @(posedge clk) en <= 15'h0006;
   @(posedge clk) {en, dis} <= {15'h0000, 15'h0002};
   @(posedge clk) dis <= 15'h0000;
   rdchk(8'hCF, 8'h04);
   @(posedge clk) sb <= 1;
   @(posedge clk) sb <= 0;
   #1 chk(busy, 15'h0000);
   rdchk(8'hCF, 8'h00);
   @(posedge clk) en <= 15'h0100;
   @(posedge clk) {en, rstn} <= {15'h0000, 1'b0};
   @(posedge clk) rstn <= 1;
   #1 chk(rd, 8'h00);
   chk(busy, 15'h0000);
   rdchk(8'hCE, 8'h00);
   rdchk(8'hBA, 8'h40);
   test_done();
end
endmodule
`default_nettype wire
